// [aor_ovr_det.sv]
// Per-channel over-range detector with pulse stretching
`timescale 1ns/1ps
`default_nettype none
module aor_ovr_det import aor_pkg::*; (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Control and flags
	aor_ovr_if.det ovr
);

	// ************************************************************
	// Level scaling
	// ************************************************************
	// Absolute sample on a 256 full-scale grid, 0..256
	function automatic logic [8:0] abs_level(input logic [SMP_W-1:0] s);
		logic [SMP_W-1:0] mag;
		mag = s[SMP_W-1] ? SMP_W'(~s + 1'b1) : s;
		return mag[SMP_W-1:SMP_W-9];
	endfunction

	logic [NCH-1:0][STR_W-1:0] hold; // Remaining stretch cycles
	logic [NCH-1:0] hit;             // Sample at or above threshold
	logic [STR_W-1:0] load_val;      // Stretch length 4*2^N
	assign load_val = STR_W'(STR_BASE) << ovr.stretch;

	// ************************************************************
	// Channel loop
	// ************************************************************
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		assign hit[c] = abs_level(ovr.sample[c]) >= {1'b0, ovr.thresh};
		// Output gated low while disabled
		assign ovr.flag[c] = ovr.enable && (hold[c] != '0);
	end

	// Each new hit restarts only its own channel; one process keeps one writer
	always_ff @(posedge clk_sys_i) begin
		for (int c = 0; c < NCH; c++) begin
			if (!rst_n_i) begin
				hold[c] <= '0;
			end else if (hit[c]) begin
				hold[c] <= load_val;
			end else if (hold[c] != '0) begin
				hold[c] <= hold[c] - 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// Shortest stretch on channel A: a hit, then the cycles that follow it
	sequence s_fast_hit;
		ovr.enable && ovr.stretch == 3'h0 && hit[0];
	endsequence
	sequence s_fast_idle;
		ovr.enable && ovr.stretch == 3'h0 && !hit[0];
	endsequence

	chk_hit_sets_flag: assert property (ovr.enable && hit[0] ##1 ovr.enable |-> ovr.flag[0])
		else $error("Over-range hit did not raise flag");
	chk_disable_low: assert property (!ovr.enable |-> ovr.flag == '0)
		else $error("Over-range flag high while disabled");
	chk_min_stretch: assert property (s_fast_hit ##1 (ovr.enable && ovr.stretch == 3'h0)
		|-> ovr.flag[0][*4])
		else $error("Over-range pulse shorter than four cycles");
	chk_stretch_end: assert property (s_fast_hit ##1 s_fast_idle[*4] |=> !ovr.flag[0])
		else $error("Over-range pulse longer than four cycles");
endmodule
`default_nettype wire

// [aor_ovr_if.sv]
// Interface between the register block and the over-range detector
`timescale 1ns/1ps
`default_nettype none
interface aor_ovr_if import aor_pkg::*; ();
	logic [NCH-1:0][SMP_W-1:0] sample; // Signed samples, one per channel
	logic [7:0] thresh;                // Absolute detection level
	logic [OVER_N_W-1:0] stretch; // Pulse stretch exponent
	logic enable;                      // Output enable
	logic [NCH-1:0] flag;              // Stretched over-range flags
	modport ctl (output sample, output thresh, output stretch, output enable, input flag);
	modport det (input sample, input thresh, input stretch, input enable, output flag);
endinterface
`default_nettype wire

// [aor_pkg.sv]
// Constants shared by the sync, over-range and power-mode register block
package aor_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [9:0] SYNC_REQ_TH_OFS = 10'h210; // Sync request threshold
	localparam logic [9:0] OVER_TH_OFS = 10'h211; // Over-range threshold
	localparam logic [9:0] OVER_CFG_OFS = 10'h213; // Over-range enable and stretch
	localparam logic [9:0] INIT_STATE_OFS = 10'h270;  // Initialization status
	localparam logic [9:0] PWR2_OFS = 10'h29A;        // Power-mode byte 2
	localparam logic [9:0] PWR3_OFS = 10'h29B;        // Power-mode byte 3
	localparam logic [9:0] PWR4_OFS = 10'h29C;        // Power-mode byte 4

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] SYNC_REQ_TH_RST = 8'h03;
	localparam logic [7:0] OVER_TH_RST = 8'hF2;
	localparam logic [7:0] OVER_CFG_RST = 8'h07;
	localparam logic [7:0] PWR2_RST = 8'h0F;
	localparam logic [7:0] PWR3_RST = 8'h04;
	localparam logic [7:0] PWR4_RST = 8'h1B;

	// ************************************************************
	// Power-mode codes
	// ************************************************************
	localparam logic [7:0] PWR2_LOW = 8'h06;
	localparam logic [7:0] PWR2_HIGH = 8'h0F;
	localparam logic [7:0] PWR3_LOW = 8'h00;
	localparam logic [7:0] PWR3_HIGH = 8'h04;
	localparam logic [7:0] PWR4_LOW = 8'h14;
	localparam logic [7:0] PWR4_HIGH = 8'h1B;

	// ************************************************************
	// Field positions and widths
	// ************************************************************
	localparam int SYNC_REQ_TH_W = 5; // Threshold field in bits 4:0
	localparam int OVER_EN_BIT = 3; // Over-range output enable
	localparam int OVER_N_W = 3; // Stretch field in bits 2:0
	localparam int INIT_DONE_BIT = 0;   // Initialization done flag
	localparam int SMP_W = 12;          // Converter sample width
	localparam int NCH = 4;             // Channel count
	localparam int LOW_CNT_W = 6;       // Consecutive-low counter width
	localparam int STR_W = 10;          // Stretch counter width, holds 4*2^7
	localparam int STR_BASE = 4;        // Stretch base, in sampling cycles
	localparam int INIT_CYCLES = 64;    // Initialization sequence length

endpackage

// [aor_regs.sv]
// Sync qualifier, over-range control, init status and power-mode registers
`timescale 1ns/1ps
`default_nettype none
module aor_regs import aor_pkg::*; #(
	parameter int INIT_LEN = INIT_CYCLES // Cycles until initialization completes
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [9:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// Serial link sync
	input wire logic sync_n_i,
	output logic resync_req_o,
	// Converter samples
	input wire logic [NCH-1:0][SMP_W-1:0] sample_i,
	// Over-range outputs
	output logic overrange_out_a_o,
	output logic overrange_out_b_o,
	output logic overrange_out_c_o,
	output logic overrange_out_d_o,
	// Status and mode
	output logic init_done_o,
	output logic low_power_o,
	output logic [7:0] power_mode_value2_o,
	output logic [7:0] power_mode_value3_o,
	output logic [7:0] power_mode_value4_o
);

	// ************************************************************
	// Register storage
	// ************************************************************
	logic [7:0] sync_request_threshold; // Sync threshold register
	logic [7:0] overrange_threshold;    // Over-range level
	logic [7:0] overrange_config;       // Enable and stretch
	logic [7:0] power_mode_byte2;       // Power-mode byte 2
	logic [7:0] power_mode_byte3;       // Power-mode byte 3
	logic [7:0] power_mode_byte4;       // Power-mode byte 4
	logic [7:0] rdata;                  // Registered read data
	logic rvalid;                       // Read answer strobe

	// ************************************************************
	// Write decode
	// ************************************************************
	wire wr_sync = reg_wr_i && reg_addr_i == SYNC_REQ_TH_OFS;
	wire wr_overrange_threshold = reg_wr_i && reg_addr_i == OVER_TH_OFS;
	wire wr_overrange_config = reg_wr_i && reg_addr_i == OVER_CFG_OFS;
	wire wr_pwr2 = reg_wr_i && reg_addr_i == PWR2_OFS;
	wire wr_pwr3 = reg_wr_i && reg_addr_i == PWR3_OFS;
	wire wr_pwr4 = reg_wr_i && reg_addr_i == PWR4_OFS;

	// Writable registers; reserved bits are stored as written,
	// software is expected to keep them zero
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			sync_request_threshold <= SYNC_REQ_TH_RST;
			overrange_threshold <= OVER_TH_RST;
			overrange_config <= OVER_CFG_RST;
			power_mode_byte2 <= PWR2_RST;
			power_mode_byte3 <= PWR3_RST;
			power_mode_byte4 <= PWR4_RST;
		end else begin
			if (wr_sync) begin
				sync_request_threshold <= reg_wdata_i;
			end
			if (wr_overrange_threshold) begin
				overrange_threshold <= reg_wdata_i;
			end
			if (wr_overrange_config) begin
				overrange_config <= reg_wdata_i;
			end
			if (wr_pwr2) begin
				power_mode_byte2 <= reg_wdata_i;
			end
			if (wr_pwr3) begin
				power_mode_byte3 <= reg_wdata_i;
			end
			if (wr_pwr4) begin
				power_mode_byte4 <= reg_wdata_i;
			end
		end
	end

	// ************************************************************
	// Initialization sequencer
	// ************************************************************
	typedef enum logic [1:0] {
		INIT_BUSY = 2'h1,
		INIT_DONE = 2'h2
	} aor_init_t;
	aor_init_t init_st;                  // Sequencer state
	aor_init_t next_init_st;             // Next sequencer state
	logic [$clog2(INIT_LEN+1)-1:0] init_cnt; // Elapsed init cycles
	wire init_last = init_cnt == ($bits(init_cnt))'(INIT_LEN - 1);

	// Sequencer transition
	always_comb begin
		case (init_st)
			INIT_BUSY: next_init_st = init_last ? INIT_DONE : INIT_BUSY;
			INIT_DONE: next_init_st = INIT_DONE;
			default: next_init_st = INIT_BUSY;
		endcase
	end

	// Counter only runs while busy
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			init_st <= INIT_BUSY;
			init_cnt <= '0;
		end else begin
			init_st <= next_init_st;
			init_cnt <= (init_st == INIT_BUSY) ? init_cnt + 1'b1 : init_cnt;
		end
	end
	wire init_done = init_st == INIT_DONE;
	assign init_done_o = init_done;

	// ************************************************************
	// Read path
	// ************************************************************
	// Unmapped offsets read zero; status reserved bits read zero
	logic [7:0] rd_mux;
	always_comb begin
		case (reg_addr_i)
			SYNC_REQ_TH_OFS: rd_mux = sync_request_threshold;
			OVER_TH_OFS: rd_mux = overrange_threshold;
			OVER_CFG_OFS: rd_mux = overrange_config;
			INIT_STATE_OFS: rd_mux = {7'h00, init_done};
			PWR2_OFS: rd_mux = power_mode_byte2;
			PWR3_OFS: rd_mux = power_mode_byte3;
			PWR4_OFS: rd_mux = power_mode_byte4;
			default: rd_mux = 8'h00;
		endcase
	end

	// Read answer one cycle after the request
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end else begin
			rdata <= reg_rd_i ? rd_mux : rdata;
			rvalid <= reg_rd_i;
		end
	end
	assign reg_rdata_o = rdata;
	assign reg_rvalid_o = rvalid;

	// ************************************************************
	// Sync request qualifier
	// ************************************************************
	logic [LOW_CNT_W-1:0] low_cnt;      // Consecutive low samples
	logic [LOW_CNT_W-1:0] next_low_cnt; // Saturating next count
	logic resync;                       // Qualified request
	wire [LOW_CNT_W-1:0] sync_limit = {1'b0, sync_request_threshold[SYNC_REQ_TH_W-1:0]};
	assign next_low_cnt = sync_n_i ? '0 : (&low_cnt ? low_cnt : low_cnt + 1'b1);

	// A short low pulse never exceeds the limit and leaves no trace
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			low_cnt <= '0;
			resync <= 1'b0;
		end else begin
			low_cnt <= next_low_cnt;
			resync <= next_low_cnt > sync_limit;
		end
	end
	assign resync_req_o = resync;

	// ************************************************************
	// Over-range detector
	// ************************************************************
	aor_ovr_if ovr ();
	assign ovr.sample = sample_i;
	assign ovr.thresh = overrange_threshold;
	assign ovr.stretch = overrange_config[OVER_N_W-1:0];
	assign ovr.enable = overrange_config[OVER_EN_BIT];

	aor_ovr_det u_det (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ovr(ovr.det)
	);
	assign overrange_out_a_o = ovr.flag[0];
	assign overrange_out_b_o = ovr.flag[1];
	assign overrange_out_c_o = ovr.flag[2];
	assign overrange_out_d_o = ovr.flag[3];

	// ************************************************************
	// Power mode
	// ************************************************************
	// Low power only when every byte holds its low code; a mixed or
	// reserved setting falls back to high performance
	wire all_low = power_mode_byte2 == PWR2_LOW && power_mode_byte3 == PWR3_LOW
		&& power_mode_byte4 == PWR4_LOW;
	assign low_power_o = all_low;
	assign power_mode_value2_o = power_mode_byte2;
	assign power_mode_value3_o = power_mode_byte3;
	assign power_mode_value4_o = power_mode_byte4;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_low_run_zero;
		!sync_n_i && sync_request_threshold[4:0] == 5'h00;
	endsequence
	sequence s_high_then_low3;
		sync_n_i ##1 (!sync_n_i && sync_request_threshold[4:0] == 5'h03)[*3];
	endsequence

	chk_sync_fast: assert property (s_low_run_zero |=> resync)
		else $error("Zero threshold did not request resync");
	chk_sync_short: assert property (s_high_then_low3 |=> !resync)
		else $error("Short sync low raised a request");
	chk_sync_qual: assert property (s_high_then_low3 ##1
		(!sync_n_i && sync_request_threshold[4:0] == 5'h03) |=> resync)
		else $error("Four low samples did not qualify");
	chk_sync_release: assert property (sync_n_i |=> !resync)
		else $error("Request held after sync released");
	// The answer carries the flag as it stood at the request edge
	chk_init_read: assert property (reg_rd_i && reg_addr_i == INIT_STATE_OFS
		|=> reg_rdata_o == {7'h00, $past(init_done_o)})
		else $error("Init status read mismatch");
	chk_init_stays: assert property (init_done_o |=> init_done_o)
		else $error("Init done dropped");
	chk_power_low: assert property (wr_pwr2 && reg_wdata_i == PWR2_LOW
		&& power_mode_byte3 == PWR3_LOW && power_mode_byte4 == PWR4_LOW
		&& !wr_pwr3 && !wr_pwr4 |=> low_power_o)
		else $error("Low power not entered");
	chk_power_mixed: assert property (power_mode_byte3 == PWR3_HIGH
		|-> !low_power_o)
		else $error("Mixed power setting reads low power");
	chk_power4_write: assert property (wr_pwr4 |=> power_mode_byte4 == $past(reg_wdata_i))
		else $error("Power byte four write lost");
endmodule
`default_nettype wire

// [aor_sync_rx.sv]
// Serial-link receiver model that drives the active-low sync request line
`timescale 1ns/1ps
`default_nettype none
module aor_sync_rx (
	// Clock
	input wire logic clk_sys_i,
	// Sync request line
	output logic sync_n_o
);
	// ************************************************************
	// Line driver
	// ************************************************************
	// Idle high: error reporting is off, so only commanded runs go low
	initial begin
		sync_n_o = 1'b1;
	end

	// Low run of len link-clock samples, changed on falling edges only
	// A zero length drives nothing, so the line is never set twice at once
	task automatic request(input int len);
		if (len > 0) begin
			sync_n_o = 1'b0;
			repeat (len) @(negedge clk_sys_i);
			sync_n_o = 1'b1;
		end
	endtask
endmodule
`default_nettype wire

// [aor_testbench.sv]
// Self-checking bench for the sync, over-range and power-mode register block
`timescale 1ns/1ps
`default_nettype none
module testbench import aor_pkg::*;;
	// ************************************************************
	// Signals
	// ************************************************************
	logic clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o, resync_req_o, sync_n;
	logic [9:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o, v2, v3, v4;
	logic [NCH-1:0][SMP_W-1:0] sample;
	logic [3:0] ovr; // Over-range outputs, bit 0 is channel A
	logic init_done, low_power, seen;
	logic [31:0] seed = 32'h2113E6E0;
	logic [7:0] rq[$]; // Expected read answers, oldest first
	int miscompares = 0, checked = 0;
	// Register table in reset order, last entry unmapped
	localparam logic [9:0] RA[8] = '{SYNC_REQ_TH_OFS, OVER_TH_OFS, OVER_CFG_OFS, INIT_STATE_OFS,
		PWR2_OFS, PWR3_OFS, PWR4_OFS, 10'h3FF};
	localparam logic [7:0] RE[8] = '{8'h03, 8'hF2, 8'h07, 8'h01, 8'h0F, 8'h04, 8'h1B, 8'h00};
	localparam logic [7:0] TH[3] = '{8'h00, 8'h03, 8'h1F};

	// Short init length keeps the run brief
	aor_regs #(.INIT_LEN(4)) DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
		.sync_n_i(sync_n), .resync_req_o(resync_req_o), .sample_i(sample),
		.overrange_out_a_o(ovr[0]), .overrange_out_b_o(ovr[1]), .overrange_out_c_o(ovr[2]),
		.overrange_out_d_o(ovr[3]), .init_done_o(init_done), .low_power_o(low_power),
		.power_mode_value2_o(v2), .power_mode_value3_o(v3), .power_mode_value4_o(v4));
	aor_sync_rx rx (.clk_sys_i(clk_sys_i), .sync_n_o(sync_n));

	// ************************************************************
	// Clock, watchdog and helpers
	// ************************************************************
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	// The whole sequence needs about 1300 cycles
	initial begin
		#(20000 * 40);
		miscompares++;
		stop_test();
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t %s: got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// Strobes stay up between back-to-back transfers; quiet() drops them
	task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
		reg_wr_i = wr;
		reg_rd_i = !wr;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge clk_sys_i);
	endtask

	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		rq.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask

	task automatic quiet();
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		@(negedge clk_sys_i);
	endtask

	// One hit on channel ch, optional second hit; other channels carry sub-threshold noise
	task automatic ovr_run(input int ch, input logic [11:0] val, input int again, input int len);
		int cnt[4];
		cnt = '{0, 0, 0, 0};
		for (int c = 0; c < 4; c++) sample[c] = (c == ch) ? val : 12'(xs() % 1936);
		for (int i = 0; i < len + 8; i++) begin
			@(negedge clk_sys_i);
			for (int c = 0; c < 4; c++) cnt[c] += (ovr[c] === 1'b1);
			// The last step belongs to the next caller, which sets every channel itself
			if (i + 1 < len + 8) sample[ch] = (i + 1 == again) ? val : 12'h000;
		end
		for (int c = 0; c < 4; c++) chk(cnt[c], (c == ch) ? len : 0, "over-range length");
	endtask

	// ************************************************************
	// Output monitor: read answers and resync request
	// ************************************************************
	always @(negedge clk_sys_i) begin
		if (reg_rvalid_o === 1'b1) begin
			if (rq.size() == 0) chk(1, 0, "unexpected read answer");
			else chk(reg_rdata_o, rq.pop_front(), "read data");
		end
		if (resync_req_o === 1'b1) seen = 1'b1;
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		rst_n_i = 1'b0;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = 10'h000;
		reg_wdata_i = 8'h00;
		sample = '0;
		seen = 1'b0;
		repeat (16) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		@(negedge clk_sys_i);
		chk(init_done, 0, "init done early");
		for (int i = 0; i < 20 && init_done !== 1'b1; i++) @(negedge clk_sys_i);
		chk(init_done, 1, "init done");
		// Reset values, read-only status, unmapped place
		foreach (RA[i]) rd(RA[i], RE[i]);
		bus(1'b1, INIT_STATE_OFS, 8'hFE);
		rd(INIT_STATE_OFS, 8'h01);
		for (int i = 0; i < 4; i++) begin
			logic [7:0] r;
			r = 8'(xs());
			bus(1'b1, OVER_TH_OFS, r);
			rd(OVER_TH_OFS, r);
		end
		bus(1'b1, OVER_TH_OFS, 8'hF2);
		quiet();
		chk({low_power, v2, v3, v4}, {1'b0, 8'h0F, 8'h04, 8'h1B}, "power reset");
		// Rate within low-power range; calibration and link held off
		// Byte two goes last, so its write completes the low set
		bus(1'b1, PWR3_OFS, 8'h00);
		bus(1'b1, PWR4_OFS, 8'h14);
		bus(1'b1, PWR2_OFS, 8'h06);
		quiet();
		chk({low_power, v2, v3, v4}, {1'b1, 8'h06, 8'h00, 8'h14}, "low power");
		bus(1'b1, PWR2_OFS, 8'h07);
		quiet();
		chk({low_power, v2}, {1'b0, 8'h07}, "reserved code");
		bus(1'b1, PWR2_OFS, 8'h0F);
		bus(1'b1, PWR3_OFS, 8'h04);
		bus(1'b1, PWR4_OFS, 8'h1B);
		quiet();
		chk({low_power, v2, v3, v4}, {1'b0, 8'h0F, 8'h04, 8'h1B}, "high performance");
		// Sync qualifier: a run of T samples is ignored, T+1 is a request
		foreach (TH[k]) begin
			bus(1'b1, SYNC_REQ_TH_OFS, TH[k]);
			quiet();
			for (int s = 0; s < 2; s++) begin
				seen = 1'b0;
				rx.request(TH[k] + s);
				repeat (3) @(negedge clk_sys_i);
				chk(seen, s, "resync request");
			end
		end
		// Over-range: gated off, every stretch code, level boundary, restart
		bus(1'b1, OVER_CFG_OFS, 8'h00);
		quiet();
		ovr_run(0, 12'd1936, 0, 0);
		for (int n = 0; n < 8; n++) begin
			bus(1'b1, OVER_CFG_OFS, 8'h08 | n[7:0]);
			quiet();
			ovr_run(n % 4, n[0] ? 12'h870 : 12'd1936, 0, 4 << n);
		end
		bus(1'b1, OVER_CFG_OFS, 8'h08);
		quiet();
		ovr_run(2, 12'd1935, 0, 0);
		ovr_run(3, 12'h800, 2, 6);
		chk(rq.size(), 0, "missing read answers");
		stop_test();
	end
endmodule
`default_nettype wire
